/* src/pwp_core.sv */
// What this block does
// RULE_01 - paged commands go to channel 0..7 held in page selector
// RULE_02 - page 0xFF applies one write to every channel enabled in global mask
// RULE_03 - global page only accepted for clear faults, operation, on/off config
// RULE_04 - paged read at global page returns undefined data and raises fault
// RULE_05 - unsupported write at global page is dropped and raises fault
// RULE_06 - host writes only 0..7 or 0xFF to the page selector
// RULE_07 - eleven-bit linear: signed 5-bit exponent, signed 11-bit mantissa
// RULE_08 - sixteen-bit linear: unsigned mantissa, fixed exponent minus thirteen
// RULE_09 - every readable value stays readable at any protection level
// RULE_10 - level 1 rejects all changes except protection level; level storable; code also accepts page writes
// RULE_11 - level 2 allows only protection level, on/off state, fault clearing; code also accepts page and global mask writes
// RULE_12 - restore command copies saved fault log back to working memory
// RULE_13 - log clear command reinitialises log area and releases lock
// RULE_14 - log block read returns 0xFF then 255 log bytes sequentially
// RULE_15 - retry count defaults to seven and applies to all retries
// RULE_16 - track minimum output voltage per channel, input voltage, die temperature
// RULE_17 - read-only shared status byte at 0xEF
// RULE_18 - read-only fault-log status byte at 0xED with nonvolatile copy
// RULE_19 - protect byte 0x80 level 1, 0x40 level 2, 0x00 none
// RULE_20 - protect pin forces at least level 2; stricter setting wins
// RULE_21 - mask bit n lets channel n respond to global page accesses
// RULE_22 - rejected write changes nothing but transaction completes normally
`timescale 1ns/1ps

module pwp_core (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic link_clock,
    input wire logic link_rst,
    input wire logic link_req,
    input wire logic [1:0] link_kind,
    input wire logic [7:0] link_cmd,
    input wire logic [15:0] link_wdata,
    output logic link_busy,
    output logic link_done,
    output logic [15:0] link_rdata,
    input wire logic wp_pin,
    input wire logic meas_valid,
    input wire logic [2:0] meas_chan,
    input wire logic [15:0] meas_vout,
    input wire logic [15:0] meas_vin,
    input wire logic [15:0] meas_temp,
    input wire logic [7:0] log_state_in,
    input wire logic [7:0] log_rd_data,
    input wire logic [7:0] shared_status_in,
    output logic [7:0] log_rd_addr,
    output logic log_restore,
    output logic log_clear,
    output logic apply_valid,
    output logic [7:0] apply_cmd,
    output logic [15:0] apply_data,
    output logic [7:0] apply_mask,
    output logic cml_fault,
    output logic [7:0] page_sel,
    output logic [7:0] global_page_channel_mask,
    output logic [7:0] retry_limit,
    output logic [7:0] protect_byte,
    output logic [1:0] protect_level
);

    localparam int L11_EXP_MSB_W = pwp_pkg::L11_EXP_MSB;

    // eleven-bit linear value scaled to a common fixed point for comparing
    // exponent gets an offset of sixteen so the shift count is never negative
    // widest result is the 11-bit mantissa moved up 31 places, inside 43 bits
    function automatic logic signed [42:0] pwp_l11_scale(input logic [15:0] v);
        logic [4:0] shamt;
        logic signed [42:0] mant;
        shamt = {~v[L11_EXP_MSB_W], v[L11_EXP_MSB_W-1:pwp_pkg::L11_EXP_LSB]};
        mant = $signed({{32{v[pwp_pkg::L11_MANT_MSB]}}, v[pwp_pkg::L11_MANT_MSB:0]});
        pwp_l11_scale = mant <<< shamt;
    endfunction

    // ---------------- link domain ----------------
    pwp_pkg::pwp_link_state_e lk_state;
    logic lk_req_tgl;
    logic [1:0] lk_kind;
    logic [7:0] lk_cmd;
    logic [15:0] lk_wdata;
    logic lk_ack_s1;
    logic lk_ack_s2;
    logic lk_ack_s3;
    wire lk_ack_edge = lk_ack_s2 ^ lk_ack_s3;
    wire lk_take = (lk_state == pwp_pkg::PWP_LK_IDLE) && link_req;
    // answer from the core side; both settle before the ack toggle is seen here
    logic core_ack_tgl;
    logic [15:0] core_rdata;

    // ack toggle: two flops, then an edge detector on the second
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            lk_ack_s1 <= 1'b0;
            lk_ack_s2 <= 1'b0;
            lk_ack_s3 <= 1'b0;
        end else begin
            lk_ack_s1 <= core_ack_tgl;
            lk_ack_s2 <= lk_ack_s1;
            lk_ack_s3 <= lk_ack_s2;
        end
    end

    // command fields stay frozen while the core side works on them
    // a request while busy is ignored; the host waits for idle
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            lk_state <= pwp_pkg::PWP_LK_IDLE;
            lk_req_tgl <= 1'b0;
            lk_kind <= pwp_pkg::PWP_KIND_READ;
            lk_cmd <= 8'h00;
            lk_wdata <= 16'h0000;
            link_done <= 1'b0;
            link_rdata <= 16'h0000;
        end else begin
            link_done <= 1'b0;
            case (lk_state)
                pwp_pkg::PWP_LK_IDLE: begin
                    if (lk_take) begin
                        lk_kind <= link_kind;
                        lk_cmd <= link_cmd;
                        lk_wdata <= link_wdata;
                        lk_req_tgl <= ~lk_req_tgl;
                        lk_state <= pwp_pkg::PWP_LK_WAIT;
                    end
                end
                pwp_pkg::PWP_LK_WAIT: begin
                    if (lk_ack_edge) begin
                        link_rdata <= core_rdata;
                        link_done <= 1'b1;
                        lk_state <= pwp_pkg::PWP_LK_DONE;
                    end
                end
                pwp_pkg::PWP_LK_DONE: begin
                    lk_state <= pwp_pkg::PWP_LK_IDLE;
                end
                default: begin
                    lk_state <= pwp_pkg::PWP_LK_IDLE;
                end
            endcase
        end
    end

    assign link_busy = (lk_state != pwp_pkg::PWP_LK_IDLE);

    // ---------------- core domain ----------------
    logic core_req_s1;
    logic core_req_s2;
    logic core_req_s3;
    logic wp_s1;
    logic wp_s2;
    logic [7:0] log_index;
    logic [15:0] vout_min [0:7];
    logic [15:0] vin_min;
    logic [15:0] temp_min;

    wire cmd_go = core_req_s2 ^ core_req_s3;
    wire is_write = (lk_kind == pwp_pkg::PWP_KIND_WRITE) || (lk_kind == pwp_pkg::PWP_KIND_SEND);
    wire is_read = (lk_kind == pwp_pkg::PWP_KIND_READ);
    wire page_global = (page_sel == pwp_pkg::PAGE_GLOBAL);

    // commands that live in this block and are not per channel
    wire cmd_local = (lk_cmd == pwp_pkg::CMD_PAGE) || (lk_cmd == pwp_pkg::CMD_WRITE_PROTECT)
        || (lk_cmd == pwp_pkg::CMD_GLOBAL_MASK) || (lk_cmd == pwp_pkg::CMD_LOG_RESTORE)
        || (lk_cmd == pwp_pkg::CMD_LOG_CLEAR) || (lk_cmd == pwp_pkg::CMD_LOG_STATE)
        || (lk_cmd == pwp_pkg::CMD_LOG_READOUT) || (lk_cmd == pwp_pkg::CMD_SHARED_STATUS)
        || (lk_cmd == pwp_pkg::CMD_RETRY_LIMIT) || (lk_cmd == pwp_pkg::CMD_VIN_MIN)
        || (lk_cmd == pwp_pkg::CMD_TEMP_MIN);
    wire cmd_paged = ~cmd_local;

    // RULE_03 global-capable commands
    wire cmd_global_ok = (lk_cmd == pwp_pkg::CMD_CLEAR_FAULTS) || (lk_cmd == pwp_pkg::CMD_OPERATION)
        || (lk_cmd == pwp_pkg::CMD_ON_OFF_CONFIG);

    // RULE_20 stricter setting wins
    wire lvl_one = (protect_byte == pwp_pkg::WP_LEVEL1);
    wire lvl_two = ~lvl_one && ((protect_byte == pwp_pkg::WP_LEVEL2) || wp_s2);
    assign protect_level = lvl_one ? pwp_pkg::PWP_LVL_ONE : (lvl_two ? pwp_pkg::PWP_LVL_TWO : pwp_pkg::PWP_LVL_NONE);

    // RULE_10 level 1 exemptions
    wire pass_one = (lk_cmd == pwp_pkg::CMD_WRITE_PROTECT) || (lk_cmd == pwp_pkg::CMD_PAGE);
    // RULE_11 level 2 exemptions
    wire pass_two = pass_one || (lk_cmd == pwp_pkg::CMD_OPERATION) || (lk_cmd == pwp_pkg::CMD_CLEAR_FAULTS)
        || (lk_cmd == pwp_pkg::CMD_GLOBAL_MASK);
    wire wp_allow = lvl_one ? pass_one : (lvl_two ? pass_two : 1'b1);

    // RULE_05 unsupported global write
    wire global_bad_wr = page_global && cmd_paged && ~cmd_global_ok;
    // RULE_04 paged read at global page
    wire global_bad_rd = page_global && cmd_paged;

    // RULE_22 rejected writes fall out here but still answer
    wire wr_ok = cmd_go && is_write && wp_allow && ~global_bad_wr;
    wire rd_go = cmd_go && is_read;

    // the per-channel minimum is read-only: a write to it stops here
    wire fwd_ok = wr_ok && cmd_paged && (lk_cmd != pwp_pkg::CMD_VOUT_MIN);

    // RULE_06 reserved page values are not stored
    wire page_val_ok = (lk_wdata[7:0] <= pwp_pkg::PAGE_LAST) || (lk_wdata[7:0] == pwp_pkg::PAGE_GLOBAL);
    // RULE_19 reserved protect encodings are not stored
    wire wp_val_ok = (lk_wdata[7:0] == pwp_pkg::WP_LEVEL1) || (lk_wdata[7:0] == pwp_pkg::WP_LEVEL2)
        || (lk_wdata[7:0] == pwp_pkg::WP_NONE);

    // RULE_01 single channel
    wire [7:0] chan_onehot = 8'h01 << page_sel[2:0];
    // RULE_02 RULE_21 global page fans out through the mask
    wire [7:0] next_apply_mask = page_global ? global_page_channel_mask : chan_onehot;

    // RULE_14 lead byte then sequential log bytes
    wire [7:0] log_byte = (log_index == 8'h00) ? pwp_pkg::LOG_LEAD_BYTE : log_rd_data;

    // RULE_09 reads never depend on protection
    logic [15:0] rd_mux;
    always_comb begin
        case (lk_cmd)
            pwp_pkg::CMD_PAGE: rd_mux = {8'h00, page_sel};
            pwp_pkg::CMD_WRITE_PROTECT: rd_mux = {8'h00, protect_byte};
            pwp_pkg::CMD_GLOBAL_MASK: rd_mux = {8'h00, global_page_channel_mask};
            // RULE_18 log status
            pwp_pkg::CMD_LOG_STATE: rd_mux = {8'h00, log_state_in};
            pwp_pkg::CMD_LOG_READOUT: rd_mux = {8'h00, log_byte};
            // RULE_17 shared status
            pwp_pkg::CMD_SHARED_STATUS: rd_mux = {8'h00, shared_status_in};
            pwp_pkg::CMD_RETRY_LIMIT: rd_mux = {8'h00, retry_limit};
            // RULE_16 minimum readback
            pwp_pkg::CMD_VOUT_MIN: rd_mux = vout_min[page_sel[2:0]];
            pwp_pkg::CMD_VIN_MIN: rd_mux = vin_min;
            pwp_pkg::CMD_TEMP_MIN: rd_mux = temp_min;
            default: rd_mux = 16'h0000;
        endcase
    end

    // RULE_04 zero for paged reads at global page
    wire [15:0] rd_word = (is_read && ~global_bad_rd) ? rd_mux : 16'h0000;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            core_req_s1 <= 1'b0;
            core_req_s2 <= 1'b0;
            core_req_s3 <= 1'b0;
            core_ack_tgl <= 1'b0;
            core_rdata <= 16'h0000;
            wp_s1 <= 1'b0;
            wp_s2 <= 1'b0;
        end else begin
            core_req_s1 <= lk_req_tgl;
            core_req_s2 <= core_req_s1;
            core_req_s3 <= core_req_s2;
            wp_s1 <= wp_pin;
            wp_s2 <= wp_s1;
            if (cmd_go) begin
                core_ack_tgl <= ~core_ack_tgl;
                core_rdata <= rd_word;
            end
        end
    end

    // configuration registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            page_sel <= pwp_pkg::PAGE_RESET;
            protect_byte <= pwp_pkg::WP_NONE;
            global_page_channel_mask <= pwp_pkg::MASK_RESET;
            // RULE_15 retry default
            retry_limit <= pwp_pkg::RETRY_RESET;
        end else if (wr_ok) begin
            if (lk_cmd == pwp_pkg::CMD_PAGE && page_val_ok) begin
                page_sel <= lk_wdata[7:0];
            end
            if (lk_cmd == pwp_pkg::CMD_WRITE_PROTECT && wp_val_ok) begin
                protect_byte <= lk_wdata[7:0];
            end
            if (lk_cmd == pwp_pkg::CMD_GLOBAL_MASK) begin
                global_page_channel_mask <= lk_wdata[7:0];
            end
            if (lk_cmd == pwp_pkg::CMD_RETRY_LIMIT) begin
                retry_limit <= lk_wdata[7:0];
            end
        end
    end

    // strobes to the channel and fault-log engines
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            apply_valid <= 1'b0;
            apply_cmd <= 8'h00;
            apply_data <= 16'h0000;
            apply_mask <= 8'h00;
            log_restore <= 1'b0;
            log_clear <= 1'b0;
            cml_fault <= 1'b0;
        end else begin
            apply_valid <= fwd_ok;
            if (fwd_ok) begin
                apply_cmd <= lk_cmd;
                apply_data <= lk_wdata;
                apply_mask <= next_apply_mask;
            end
            // RULE_12 restore strobe
            log_restore <= wr_ok && (lk_cmd == pwp_pkg::CMD_LOG_RESTORE);
            // RULE_13 clear and unlock strobe
            log_clear <= wr_ok && (lk_cmd == pwp_pkg::CMD_LOG_CLEAR);
            // RULE_04 RULE_05 comms fault
            cml_fault <= (cmd_go && is_write && global_bad_wr) || (rd_go && global_bad_rd);
        end
    end

    // fault-log byte pointer; any other command restarts the block
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            log_index <= 8'h00;
        end else if (cmd_go) begin
            if (rd_go && lk_cmd == pwp_pkg::CMD_LOG_READOUT) begin
                log_index <= (log_index == pwp_pkg::LOG_LAST_INDEX) ? 8'h00 : log_index + 8'h01;
            end else begin
                log_index <= 8'h00;
            end
        end
    end

    // log byte k of the engine sits behind readout index k+1
    assign log_rd_addr = log_index - 8'h01;

    // RULE_08 unsigned compare is exact for the fixed exponent
    // RULE_16 minimum trackers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < 8; i++) begin
                vout_min[i] <= pwp_pkg::L16_MIN_RESET;
            end
            vin_min <= pwp_pkg::L11_MIN_RESET;
            temp_min <= pwp_pkg::L11_MIN_RESET;
        end else if (meas_valid) begin
            if (meas_vout < vout_min[meas_chan]) begin
                vout_min[meas_chan] <= meas_vout;
            end
            // RULE_07 decode exponent and mantissa to compare
            if (pwp_l11_scale(meas_vin) < pwp_l11_scale(vin_min)) begin
                vin_min <= meas_vin;
            end
            if (pwp_l11_scale(meas_temp) < pwp_l11_scale(temp_min)) begin
                temp_min <= meas_temp;
            end
        end
    end

endmodule // pwp_core

/* src/pwp_pkg.sv */
package pwp_pkg;

    // command codes served by this block
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;
    localparam logic [7:0] CMD_GLOBAL_MASK = 8'he4;
    localparam logic [7:0] CMD_LOG_RESTORE = 8'heb;
    localparam logic [7:0] CMD_LOG_CLEAR = 8'hec;
    localparam logic [7:0] CMD_LOG_STATE = 8'hed;
    localparam logic [7:0] CMD_LOG_READOUT = 8'hee;
    localparam logic [7:0] CMD_SHARED_STATUS = 8'hef;
    localparam logic [7:0] CMD_RETRY_LIMIT = 8'hf7;
    localparam logic [7:0] CMD_VOUT_MIN = 8'hfb;
    localparam logic [7:0] CMD_VIN_MIN = 8'hfc;
    localparam logic [7:0] CMD_TEMP_MIN = 8'hfd;

    // page selector values
    localparam logic [7:0] PAGE_GLOBAL = 8'hff;
    localparam logic [7:0] PAGE_LAST = 8'h07;
    localparam logic [7:0] PAGE_RESET = 8'h00;

    // write-protect byte encodings
    localparam logic [7:0] WP_LEVEL1 = 8'h80;
    localparam logic [7:0] WP_LEVEL2 = 8'h40;
    localparam logic [7:0] WP_NONE = 8'h00;

    // reset values
    localparam logic [7:0] RETRY_RESET = 8'h07;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic [15:0] L16_MIN_RESET = 16'hffff;
    localparam logic [15:0] L11_MIN_RESET = 16'h7bff;

    // fault-log block readout
    localparam logic [7:0] LOG_LEAD_BYTE = 8'hff;
    localparam logic [7:0] LOG_LAST_INDEX = 8'hff;

    // linear formats
    localparam int L11_EXP_MSB = 15;
    localparam int L11_EXP_LSB = 11;
    localparam int L11_MANT_MSB = 10;
    localparam int L16_EXPONENT = -13;

    typedef enum logic [1:0] {
        PWP_KIND_WRITE = 2'b00,
        PWP_KIND_SEND = 2'b01,
        PWP_KIND_READ = 2'b10
    } pwp_kind_e;

    typedef enum logic [1:0] {
        PWP_LVL_NONE = 2'b00,
        PWP_LVL_TWO = 2'b01,
        PWP_LVL_ONE = 2'b11
    } pwp_level_e;

    typedef enum logic [1:0] {
        PWP_LK_IDLE = 2'b00,
        PWP_LK_WAIT = 2'b01,
        PWP_LK_DONE = 2'b11
    } pwp_link_state_e;

endpackage

/* tb/pwp_core_chk.sv */
`timescale 1ns/1ps
module pwp_core_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic link_clock,
    input wire logic link_rst,
    input wire logic link_busy,
    input wire logic link_done,
    input wire logic wp_pin,
    input wire logic apply_valid,
    input wire logic [7:0] apply_cmd,
    input wire logic [7:0] apply_mask,
    input wire logic log_restore,
    input wire logic log_clear,
    input wire logic cml_fault,
    input wire logic [7:0] page_sel,
    input wire logic [7:0] global_page_channel_mask,
    input wire logic [7:0] retry_limit,
    input wire logic [7:0] protect_byte,
    input wire logic [1:0] protect_level
);
    wire logic glb = page_sel == 8'hff;
    wire logic evt = apply_valid || log_restore || log_clear;
    property p_page;
        @(posedge clock) disable iff (sys_rst)
        apply_valid |-> apply_mask == (glb ? global_page_channel_mask : 8'h01 << page_sel[2:0]);
    endproperty
    a_page: assert property (p_page) else $error("apply mask wrong");
    property p_glob;
        @(posedge clock) disable iff (sys_rst) apply_valid && glb |-> apply_cmd inside {8'h01, 8'h02, 8'h03};
    endproperty
    a_glob: assert property (p_glob) else $error("global apply of bad command");
    property p_pgval;
        @(posedge clock) disable iff (sys_rst) page_sel <= 8'h07 || glb;
    endproperty
    a_pgval: assert property (p_pgval) else $error("reserved page held");
    property p_wpval;
        @(posedge clock) disable iff (sys_rst)
        (protect_byte inside {8'h00, 8'h40, 8'h80}) && ((protect_byte == 8'h80) == (protect_level == 2'b11));
    endproperty
    a_wpval: assert property (p_wpval) else $error("protect byte or level wrong");
    property p_pin;
        @(posedge clock) disable iff (sys_rst) wp_pin [*4] |-> protect_level != 2'b00;
    endproperty
    a_pin: assert property (p_pin) else $error("pin did not protect");
    property p_lv1;
        @(posedge clock) disable iff (sys_rst) protect_level == 2'b11 && $past(protect_level) == 2'b11 |-> !evt;
    endproperty
    a_lv1: assert property (p_lv1) else $error("change under level one");
    property p_lv2;
        @(posedge clock) disable iff (sys_rst) protect_level == 2'b01 && $past(protect_level) == 2'b01
        |-> !(log_restore || log_clear || (apply_valid && apply_cmd == 8'h02));
    endproperty
    a_lv2: assert property (p_lv2) else $error("change under level two");
    property p_retry;
        @(posedge clock) disable iff (sys_rst) $changed(retry_limit) |-> $past(protect_level) == 2'b00;
    endproperty
    a_retry: assert property (p_retry) else $error("retry changed while protected");
    property p_done;
        @(posedge link_clock) disable iff (link_rst) link_done |-> link_busy ##1 (!link_done && !link_busy);
    endproperty
    a_done: assert property (p_done) else $error("transfer did not close");
    property p_flt;
        @(posedge clock) disable iff (sys_rst) cml_fault |=> !cml_fault;
    endproperty
    a_flt: assert property (p_flt) else $error("fault pulse too long");
endmodule // pwp_core_chk

/* tb/pwp_host_model.sv */
`timescale 1ns/1ps
module pwp_host_model (
    input wire logic link_clock,
    input wire logic link_busy,
    input wire logic link_done,
    input wire logic [15:0] link_rdata,
    output logic link_req,
    output logic [1:0] link_kind,
    output logic [7:0] link_cmd,
    output logic [15:0] link_wdata
);
    initial begin
        link_req = 1'b0;
        link_kind = 2'b00;
        link_cmd = 8'h00;
        link_wdata = 16'h0000;
    end
    task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d, input int gap,
                        output logic [15:0] r, output logic ok);
        int n;
        n = 0;
        repeat (gap) @(posedge link_clock);
        while (link_busy !== 1'b0 && n < 20) begin
            @(posedge link_clock);
            n++;
        end
        link_req <= 1'b1;
        link_kind <= k;
        link_cmd <= c;
        link_wdata <= d;
        @(posedge link_clock);
        link_req <= 1'b0;
        // released fields show the inverse of the last value
        link_kind <= ~k;
        link_cmd <= ~c;
        link_wdata <= ~d;
        n = 0;
        while (link_done !== 1'b1 && n < 40) begin
            @(posedge link_clock);
            n++;
        end
        r = link_rdata;
        ok = n < 40;
    endtask
endmodule // pwp_host_model

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clock, sys_rst, link_clock, link_rst, wp_pin, meas_valid, ok;
    logic link_req, link_busy, link_done, log_restore, log_clear, apply_valid, cml_fault;
    logic [1:0] link_kind, protect_level;
    logic [2:0] meas_chan;
    logic [7:0] link_cmd, log_rd_addr, apply_cmd, apply_mask, page_sel, global_page_channel_mask;
    logic [7:0] retry_limit, protect_byte, log_state_in, log_rd_data, shared_status_in;
    logic [15:0] link_wdata, link_rdata, apply_data, meas_vout, meas_vin, meas_temp, rd;
    int bad_count = 0;
    int checks = 0;
    int evt = 0;
    int flt = 0;
    int seed = 32'h2509;
    pwp_core DUT (.*);
    pwp_host_model host (.*);
    assign log_rd_data = log_rd_addr ^ 8'h5a;
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        link_clock = 1'b0;
        #7;
        forever #24 link_clock = ~link_clock;
    end
    always @(posedge clock) begin
        if (apply_valid === 1'b1 || log_restore === 1'b1 || log_clear === 1'b1)
            evt <= evt + 1;
        if (cml_fault === 1'b1)
            flt <= flt + 1;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic io(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d);
        host.xfer(k, c, d, {$random(seed)} % 3, rd, ok);
        if (ok !== 1'b1) begin
            bad_count++;
            test_done;
        end
    endtask
    function automatic longint l11(input logic [15:0] v);
        return longint'($signed(v[10:0])) <<< (int'($signed(v[15:11])) + 16);
    endfunction
    initial begin
        int i, lv, i0;
        logic [2:0] ch;
        logic [6:0] allow;
        logic [7:0] m0, r0, rexp, c;
        logic [7:0] cmds[7];
        logic [15:0] a, b, t, mi, mt;
        logic [15:0] mv[8];
        sys_rst = 1'b1;
        link_rst = 1'b1;
        wp_pin = 1'b0;
        meas_valid = 1'b0;
        meas_chan = 3'h0;
        meas_vout = 16'h0000;
        meas_vin = 16'h0000;
        meas_temp = 16'h0000;
        log_state_in = 8'($random(seed));
        shared_status_in = 8'($random(seed));
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge link_clock);
        link_rst <= 1'b0;
        @(posedge link_clock);
        check({8'h00, page_sel}, 16'h0000);
        check({8'h00, global_page_channel_mask}, {8'h00, pwp_pkg::MASK_RESET});
        io(2'b10, pwp_pkg::CMD_RETRY_LIMIT, 16'h0000);
        check(rd, {8'h00, pwp_pkg::RETRY_RESET});
        io(2'b10, pwp_pkg::CMD_LOG_STATE, 16'h0000);
        check(rd, {8'h00, log_state_in});
        io(2'b10, pwp_pkg::CMD_SHARED_STATUS, 16'h0000);
        check(rd, {8'h00, shared_status_in});
        for (i = 0; i < 8; i++) begin
            a = {8'h00, 8'($random(seed))};
            io(2'b00, pwp_pkg::CMD_PAGE, 16'(i));
            io(2'b00, pwp_pkg::CMD_OPERATION, a);
            check({apply_cmd, apply_mask}, {pwp_pkg::CMD_OPERATION, 8'h01 << i});
            check(apply_data, a);
        end
        io(2'b00, pwp_pkg::CMD_PAGE, 16'h0010);
        check({8'h00, page_sel}, 16'h0007);
        m0 = 8'($random(seed));
        io(2'b00, pwp_pkg::CMD_GLOBAL_MASK, {8'h00, m0});
        io(2'b00, pwp_pkg::CMD_PAGE, 16'h00ff);
        for (c = 8'h01; c < 8'h04; c++) begin
            io(2'b00, c, {8'h00, c});
            check({apply_cmd, apply_mask}, {c, m0});
        end
        i0 = flt;
        io(2'b00, 8'h21, 16'h1234);
        check({apply_cmd, 8'(flt - i0)}, 16'h0301);
        io(2'b10, pwp_pkg::CMD_VOUT_MIN, 16'h0000);
        check({rd[7:0], 8'(flt - i0)}, 16'h0002);
        for (i = 0; i < 8; i++)
            mv[i] = pwp_pkg::L16_MIN_RESET;
        mi = pwp_pkg::L11_MIN_RESET;
        mt = pwp_pkg::L11_MIN_RESET;
        for (i = 0; i < 12; i++) begin
            @(posedge clock);
            ch = 3'($random(seed));
            a = 16'($random(seed));
            b = 16'($random(seed));
            t = 16'($random(seed));
            meas_valid <= 1'b1;
            meas_chan <= ch;
            meas_vout <= a;
            meas_vin <= b;
            meas_temp <= t;
            if (a < mv[ch])
                mv[ch] = a;
            if (l11(b) < l11(mi))
                mi = b;
            if (l11(t) < l11(mt))
                mt = t;
        end
        @(posedge clock);
        meas_valid <= 1'b0;
        io(2'b10, pwp_pkg::CMD_VIN_MIN, 16'h0000);
        check(rd, mi);
        io(2'b10, pwp_pkg::CMD_TEMP_MIN, 16'h0000);
        check(rd, mt);
        for (i = 0; i < 8; i++) begin
            io(2'b00, pwp_pkg::CMD_PAGE, 16'(i));
            io(2'b10, pwp_pkg::CMD_VOUT_MIN, 16'h0000);
            check(rd, mv[i]);
        end
        for (i = 0; i < 258; i++) begin
            io(2'b10, pwp_pkg::CMD_LOG_READOUT, 16'h0000);
            check(rd, {8'h00, (i % 256 == 0) ? pwp_pkg::LOG_LEAD_BYTE : 8'(i - 1) ^ 8'h5a});
        end
        io(2'b10, pwp_pkg::CMD_LOG_STATE, 16'h0000);
        io(2'b10, pwp_pkg::CMD_LOG_READOUT, 16'h0000);
        check(rd, 16'h00ff);
        cmds = '{8'h01, 8'h02, 8'h03, 8'he4, 8'heb, 8'hec, 8'hf7};
        rexp = pwp_pkg::RETRY_RESET;
        for (lv = 0; lv < 3; lv++) begin
            io(2'b00, pwp_pkg::CMD_WRITE_PROTECT, {8'h00, lv == 0 ? 8'h00 : lv == 1 ? 8'h40 : 8'h80});
            allow = lv == 0 ? 7'h7f : lv == 1 ? 7'h0d : 7'h00;
            check({14'h0, protect_level}, lv == 0 ? 16'h0 : lv == 1 ? 16'h1 : 16'h3);
            for (i = 0; i < 7; i++) begin
                i0 = evt;
                m0 = global_page_channel_mask;
                r0 = retry_limit;
                io(cmds[i] inside {8'heb, 8'hec} ? 2'b01 : 2'b00, cmds[i], {8'h00, i == 3 ? ~m0 : ~r0});
                if (i == 6 && lv == 0)
                    rexp = ~rexp;
                check(16'(evt != i0 || global_page_channel_mask !== m0 || retry_limit !== r0),
                      16'(allow[i]));
            end
            io(2'b10, pwp_pkg::CMD_RETRY_LIMIT, 16'h0000);
            check(rd, {8'h00, rexp});
        end
        io(2'b00, pwp_pkg::CMD_WRITE_PROTECT, 16'h0020);
        check({8'h00, protect_byte}, 16'h0080);
        io(2'b00, pwp_pkg::CMD_PAGE, 16'h0005);
        check({8'h00, page_sel}, 16'h0005);
        io(2'b00, pwp_pkg::CMD_WRITE_PROTECT, 16'h0000);
        @(posedge clock);
        wp_pin <= 1'b1;
        repeat (4) @(posedge clock);
        check({14'h0, protect_level}, 16'h0001);
        i0 = evt;
        io(2'b00, pwp_pkg::CMD_ON_OFF_CONFIG, 16'h0001);
        check(16'(evt - i0), 16'h0000);
        io(2'b00, pwp_pkg::CMD_WRITE_PROTECT, 16'h0080);
        check({14'h0, protect_level}, 16'h0003);
        test_done;
    end
endmodule // tb
bind pwp_core pwp_core_chk u_chk (.*);
